// *** logic/lfs_supervisor.sv ***
// Purpose: Fault classification, gate drive gating and open-drain fault flags
// Assumes: OSC_TICK is a one-cycle pulse per oscillator period on SYS_CLK
// Notes: Flags are output-enable style; enable high pulls the pin low
`timescale 1ns/1ps
module lfs_supervisor #(
  parameter int unsigned OPEN_RETRY = lfs_pkg::OPEN_RETRY_PERIODS,
  parameter int unsigned BLANK = lfs_pkg::BLANK_PERIODS,
  parameter int unsigned DISABLE = lfs_pkg::DISABLE_PERIODS
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // Oscillator period enable
  input wire logic OSC_TICK,
  // Comparator results and enable pin, asynchronous
  input wire lfs_pkg::lfs_cmp_t CMP_IN,
  input wire logic ENABLE_PIN,
  // Regulator gate request
  input wire logic GATE_REQ,
  // Gate drive
  output logic SWITCH_GATE_DRIVE,
  // Short fault flag pin
  input wire logic SHORT_FAULT_FLAG_I,
  output logic SHORT_FAULT_FLAG_O,
  output logic SHORT_FAULT_FLAG_OE,
  // Warning fault flag pin
  input wire logic WARNING_FAULT_FLAG_I,
  output logic WARNING_FAULT_FLAG_O,
  output logic WARNING_FAULT_FLAG_OE,
  // Status
  output logic SLEEP,
  output lfs_pkg::lfs_latch_t FAULT_STATUS
);
  localparam int unsigned CW = lfs_pkg::CNT_W + 1;
  localparam logic [CW-1:0] OPEN_LAST = CW'(OPEN_RETRY - 1);
  localparam logic [CW-1:0] BLANK_LAST = CW'(BLANK - 1);
  localparam logic [CW-1:0] DIS_LAST = CW'(DISABLE - 1);

  lfs_pkg::lfs_cmp_t cmp;
  logic en_s;
  logic ff1_s;
  logic ff2_s;
  logic [2:0] sync_q;

  lfs_sync #(.W(lfs_pkg::CMP_N)) u_cmp_sync (
    .clk(SYS_CLK),
    .rst(RESET),
    .d(CMP_IN),
    .q(cmp)
  );

  lfs_sync #(.W(3)) u_pin_sync (
    .clk(SYS_CLK),
    .rst(RESET),
    .d({ENABLE_PIN, SHORT_FAULT_FLAG_I, WARNING_FAULT_FLAG_I}),
    .q(sync_q)
  );

  assign en_s = sync_q[2];
  assign ff1_s = sync_q[1];
  assign ff2_s = sync_q[0];

  logic en_prev_q;
  logic [CW-1:0] blank_cnt_q;
  logic blank_q;
  logic [CW-1:0] dis_cnt_q;
  logic sleep_q;
  logic open_q;
  logic [CW-1:0] open_cnt_q;
  lfs_pkg::lfs_latch_t lat_q;
  logic [2:0] ff1_rel_q;
  logic [2:0] ff2_rel_q;

  wire en_rise = en_s & ~en_prev_q;
  wire dis_done = OSC_TICK & ~en_s & (dis_cnt_q == DIS_LAST);
  wire clear_latch = dis_done;
  wire led_short = cmp.ref_led_short | cmp.nonref_led_short;
  wire detect_on = ~blank_q & en_s & ~sleep_q;
  wire det_short = detect_on & led_short & cmp.under_current;
  wire det_over = detect_on & cmp.over_current;
  wire det_rev = detect_on & cmp.reverse_current;
  wire det_str = detect_on & cmp.string_short;
  wire open_now = cmp.string_open & ~sleep_q;
  wire open_any = open_q | open_now;
  wire open_done = OSC_TICK & open_q & (open_cnt_q == OPEN_LAST);
  wire ff1_fault = lat_q.output_short | lat_q.over_current |
    lat_q.reverse_current | lat_q.string_short;
  wire ff2_fault = open_any | led_short | cmp.under_current;
  // Outside pull-down of a released flag overrides the drive disable.
  // The pin readback lags the release by three cycles, so a low level is
  // only trusted once the flag has been released for that long.
  wire ff1_override = ff1_fault & (&ff1_rel_q) & ~ff1_s;
  wire ff2_override = open_any & (&ff2_rel_q) & ~ff2_s;
  wire gate_kill = (ff1_fault & ~ff1_override) |
    (open_any & ~ff2_override);
  wire gate_d = GATE_REQ & en_s & ~sleep_q & ~gate_kill;

  // Blanking restarts on each enable rise, also covering start-up
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      en_prev_q <= 1'b0;
      blank_q <= 1'b1;
      blank_cnt_q <= '0;
    end
    else
    begin
      en_prev_q <= en_s;
      if (en_rise | ~en_s)
      begin
        blank_q <= 1'b1;
        blank_cnt_q <= '0;
      end
      else if (OSC_TICK & blank_q)
      begin
        blank_cnt_q <= blank_cnt_q + CW'(1);
        if (blank_cnt_q == BLANK_LAST)
          blank_q <= 1'b0;
      end
    end
  end

  // Disable timer: enable held low clears latches and enters sleep
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      dis_cnt_q <= '0;
      sleep_q <= 1'b0;
    end
    else if (en_s)
    begin
      dis_cnt_q <= '0;
      sleep_q <= 1'b0;
    end
    else if (OSC_TICK & ~sleep_q)
    begin
      dis_cnt_q <= dis_cnt_q + CW'(1);
      if (dis_done)
        sleep_q <= 1'b1;
    end
  end

  // Open retry: hold off for the timeout, then recheck
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET | sleep_q)
    begin
      open_q <= 1'b0;
      open_cnt_q <= '0;
    end
    else if (!open_q)
    begin
      open_cnt_q <= '0;
      if (open_now)
        open_q <= 1'b1;
    end
    else if (open_done)
    begin
      open_q <= 1'b0;
      open_cnt_q <= '0;
    end
    else if (OSC_TICK)
      open_cnt_q <= open_cnt_q + CW'(1);
  end

  // Latched short-flag faults; detection wins over the clear
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      lat_q <= '0;
    else
    begin
      lat_q.open_fault <= open_any;
      lat_q.output_short <= det_short | (lat_q.output_short & ~clear_latch);
      lat_q.over_current <= det_over | (lat_q.over_current & ~clear_latch);
      lat_q.reverse_current <= det_rev | (lat_q.reverse_current & ~clear_latch);
      lat_q.string_short <= det_str | (lat_q.string_short & ~clear_latch);
    end
  end

  // Release history, aligned with the output flop plus the pin synchroniser
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      ff1_rel_q <= '0;
      ff2_rel_q <= '0;
    end
    else
    begin
      ff1_rel_q <= {ff1_rel_q[1:0], ff1_fault};
      ff2_rel_q <= {ff2_rel_q[1:0], ff2_fault};
    end
  end

  // Pin outputs, registered
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      SWITCH_GATE_DRIVE <= 1'b0;
      SHORT_FAULT_FLAG_OE <= 1'b0;
      WARNING_FAULT_FLAG_OE <= 1'b0;
      SLEEP <= 1'b0;
      FAULT_STATUS <= '0;
    end
    else
    begin
      SWITCH_GATE_DRIVE <= gate_d;
      SHORT_FAULT_FLAG_OE <= ~ff1_fault;
      WARNING_FAULT_FLAG_OE <= ~ff2_fault;
      SLEEP <= sleep_q;
      FAULT_STATUS <= lat_q;
    end
  end

  assign SHORT_FAULT_FLAG_O = 1'b0;
  assign WARNING_FAULT_FLAG_O = 1'b0;
endmodule : lfs_supervisor

// *** include/lfs_pkg.sv ***
// Purpose: Shared constants and types for the LED string fault supervisor
// Assumes: Oscillator period enable arrives once per switching cycle
// Notes: Counts are in oscillator periods, not system clocks
// Functional notes
// - Open string forces gate drive low immediately, no blanking.
// - Open string releases warning flag and holds open state until timeout.
// - Open timeout lasts 32768 oscillator periods.
// - After timeout, re-enable drive and recheck open; repeat while present. The code keeps gate drive low while open is still present.
// - Shorted LED releases warning flag, switching continues.
// - Shorted LED indication does not latch; follows the condition.
// - Undercurrent releases warning flag while still driving.
// - Warning flag pulled low again once current recovers.
// - Shorted LED plus undercurrent together is an output short; releases short flag.
// - Short, overcurrent, reverse current, string short blanked after start and enable.
// - Overcurrent releases short flag.
// - Reverse current above threshold releases short flag.
// - String voltage below string-short threshold releases short flag.
// - Any short-flag fault holds gate drive low.
// - Short-flag faults latch until power cycle or long enable low.
// - Fault blanking lasts 1024 oscillator periods.
// - Disable time is 32768 oscillator periods of enable held low.
// - Flag pulled low externally during its fault overrides drive disable.
// - Open detection is never blanked.
package lfs_pkg;
  localparam int unsigned OPEN_RETRY_PERIODS = 32768;
  localparam int unsigned BLANK_PERIODS = 1024;
  localparam int unsigned DISABLE_PERIODS = 32768;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned CMP_N = 7;

  typedef struct packed {
    logic string_open;
    logic ref_led_short;
    logic nonref_led_short;
    logic under_current;
    logic over_current;
    logic reverse_current;
    logic string_short;
  } lfs_cmp_t;

  typedef struct packed {
    logic open_fault;
    logic output_short;
    logic over_current;
    logic reverse_current;
    logic string_short;
  } lfs_latch_t;
endpackage : lfs_pkg

// *** logic/lfs_sync.sv ***
// Purpose: Two-flop synchroniser for a bus of independent levels
// Assumes: Each bit is a slow level, no word coherence needed
// Notes: First stage is read only by the second
`timescale 1ns/1ps
module lfs_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : lfs_sync

// *** testbench/lfs_supervisor_assertions.sv ***
// Purpose: Port checks for lfs_supervisor
// Assumes: One clock, three-cycle input latency
// Notes: Bound from the bench top
`timescale 1ns/1ps
module lfs_sva (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // Watched ports
  input wire lfs_pkg::lfs_cmp_t CMP_IN,
  input wire logic ENABLE_PIN,
  input wire logic SWITCH_GATE_DRIVE,
  input wire logic SHORT_FAULT_FLAG_I,
  input wire logic SHORT_FAULT_FLAG_O,
  input wire logic SHORT_FAULT_FLAG_OE,
  input wire logic WARNING_FAULT_FLAG_I,
  input wire logic WARNING_FAULT_FLAG_OE,
  input wire logic SLEEP,
  input wire lfs_pkg::lfs_latch_t FAULT_STATUS
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);
  property p_od;
    !$past(RESET) |-> !SHORT_FAULT_FLAG_O &&
      (SHORT_FAULT_FLAG_OE == (FAULT_STATUS[3:0] == 4'h0));
  endproperty
  a_od: assert property (p_od) else $error("flag data high");
  property p_open;
    CMP_IN.string_open [*3] |=> !SWITCH_GATE_DRIVE || !WARNING_FAULT_FLAG_I; endproperty
  a_open: assert property (p_open) else $error("open gate on");
  property p_owarn; CMP_IN.string_open [*3] |=> !WARNING_FAULT_FLAG_OE; endproperty
  a_owarn: assert property (p_owarn) else $error("open flag held");
  property p_led;
    (CMP_IN.ref_led_short || CMP_IN.nonref_led_short) [*3] |=> !WARNING_FAULT_FLAG_OE;
  endproperty
  a_led: assert property (p_led) else $error("short flag held");
  property p_uc; CMP_IN.under_current [*3] |=> !WARNING_FAULT_FLAG_OE; endproperty
  a_uc: assert property (p_uc) else $error("undercurrent flag held");
  property p_stop;
    ((|FAULT_STATUS[3:0]) && SHORT_FAULT_FLAG_I) [*4] |-> !SWITCH_GATE_DRIVE; endproperty
  a_stop: assert property (p_stop) else $error("gate on in fault");
  property p_hold;
    ENABLE_PIN |=> (FAULT_STATUS[3:0] & $past(FAULT_STATUS[3:0])) == $past(FAULT_STATUS[3:0]);
  endproperty
  a_hold: assert property (p_hold) else $error("latch lost");
  property p_blank;
    $rose(|FAULT_STATUS[3:0]) |-> $past(ENABLE_PIN, 4) && $past(ENABLE_PIN, 8); endproperty
  a_blank: assert property (p_blank) else $error("fault in blanking");
  c_sleep: cover property ($rose(SLEEP));
  c_warn: cover property ($fell(WARNING_FAULT_FLAG_OE));
  c_osh: cover property ($rose(FAULT_STATUS.output_short));
endmodule : lfs_sva

// *** testbench/lfs_monitor.sv ***
// Purpose: External monitor with flag pull-ups
// Assumes: Pull-ups on both open-drain flags
// Notes: Hold inputs force a flag low
`timescale 1ns/1ps
module lfs_monitor (
  // Device pin drive
  input wire logic short_oe,
  input wire logic warn_oe,
  // Monitor pull-down
  input wire logic short_hold_lo,
  input wire logic warn_hold_lo,
  // Resolved pins
  output logic short_pin,
  output logic warn_pin
);
  assign short_pin = !(short_oe || short_hold_lo);
  assign warn_pin = !(warn_oe || warn_hold_lo);
endmodule : lfs_monitor

// *** testbench/tb_led_string_fault_supervisor.sv ***
// Purpose: Self-checking bench for the fault supervisor
// Assumes: Counts 8, 4, 8; tick every second cycle
// Notes: Random warning-only mixes
`timescale 1ns/1ps
module tb_led_string_fault_supervisor;
  localparam int unsigned OR_N = 8;
  localparam int unsigned BL_N = 4;
  localparam int unsigned DS_N = 8;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic tick = 1'h0;
  logic en = 1'h1;
  logic req = 1'h1;
  logic s_lo = 1'h0;
  logic w_lo = 1'h0;
  logic gate, s_pin, s_oe, w_pin, w_oe, slp;
  logic s_o, w_o;
  lfs_pkg::lfs_cmp_t cmp = 7'h00;
  lfs_pkg::lfs_latch_t st;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  lfs_pkg::lfs_cmp_t lat [4] = '{7'h04, 7'h02, 7'h01, 7'h28};
  lfs_pkg::lfs_latch_t exl [4] = '{5'h04, 5'h02, 5'h01, 5'h08};
  lfs_supervisor #(.OPEN_RETRY(OR_N), .BLANK(BL_N), .DISABLE(DS_N)) u_dut (
    .SYS_CLK(clk), .RESET(rst), .OSC_TICK(tick), .CMP_IN(cmp), .ENABLE_PIN(en),
    .GATE_REQ(req), .SWITCH_GATE_DRIVE(gate), .SHORT_FAULT_FLAG_I(s_pin),
    .SHORT_FAULT_FLAG_O(s_o), .SHORT_FAULT_FLAG_OE(s_oe), .WARNING_FAULT_FLAG_I(w_pin),
    .WARNING_FAULT_FLAG_O(w_o), .WARNING_FAULT_FLAG_OE(w_oe), .SLEEP(slp), .FAULT_STATUS(st));
  lfs_monitor u_mon (.short_oe(s_oe), .warn_oe(w_oe), .short_hold_lo(s_lo),
    .warn_hold_lo(w_lo), .short_pin(s_pin), .warn_pin(w_pin));
  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    tick <= ~tick;
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  function automatic logic exw(lfs_pkg::lfs_cmp_t c);
    return !(c.ref_led_short || c.nonref_led_short || c.under_current);
  endfunction : exw
  task automatic chk(string n, logic [5:0] e, logic [5:0] g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic w(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : w
  task automatic end_of_test();
    if (error_cnt == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  initial
  begin
    lfs_pkg::lfs_cmp_t r;
    void'($urandom(53));
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    w(24);
    chk("idle", 6'h07, {gate, s_oe, w_oe});
    chk("fdata", 6'h00, {s_o, w_o});
    repeat (24)
    begin
      r = 7'($urandom) & 7'h38;
      if (r.under_current) r[5:4] = 2'h0;
      @(posedge clk) cmp <= r;
      w(5);
      chk("warn", {1'h1, exw(r)}, {gate, w_oe});
      chk("wgate", 6'h01, gate);
    end
    @(posedge clk) cmp <= 7'h40;
    w(4);
    chk("open", 6'h00, {gate, w_oe});
    w(4 * OR_N);
    chk("retry", 6'h00, {gate, w_oe});
    @(posedge clk) w_lo <= 1'h1;
    w(5);
    chk("wovr", 6'h01, gate);
    chk("ofst", 6'h10, st);
    @(posedge clk) cmp <= 7'h00;
    w(2);
    @(posedge clk) w_lo <= 1'h0;
    w(4 * OR_N + 8);
    chk("oclr", 6'h03, {gate, w_oe});
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk) cmp <= lat[i];
      w(4);
      @(posedge clk) cmp <= 7'h00;
      w(6);
      chk("latch", exl[i], st);
      chk("sff", 6'h00, {gate, s_oe});
      @(posedge clk) s_lo <= 1'h1;
      w(5);
      chk("sovr", 6'h03, {gate, |st});
      @(posedge clk) s_lo <= 1'h0;
      en <= 1'h0;
      w(2 * DS_N + 8);
      chk("sleep", 6'h20, {slp, st});
      @(posedge clk) en <= 1'h1;
      cmp <= 7'h04;
      w(3);
      @(posedge clk) cmp <= 7'h00;
      w(2 * BL_N + 8);
      chk("blank", 6'h20, {s_oe, st});
    end
    end_of_test();
  end
endmodule : tb_led_string_fault_supervisor
bind lfs_supervisor lfs_sva u_sva (.SYS_CLK, .RESET, .CMP_IN, .ENABLE_PIN,
  .SWITCH_GATE_DRIVE, .SHORT_FAULT_FLAG_I, .SHORT_FAULT_FLAG_O, .SHORT_FAULT_FLAG_OE,
  .WARNING_FAULT_FLAG_I, .WARNING_FAULT_FLAG_OE, .SLEEP, .FAULT_STATUS);
